// ===== hdl/atpb_pkg.sv
// Notes on behaviour
// [RL1] Byte 0 is 40h, byte 1 reserved
// [RL2] Header, two format bytes, then entries
// [RL3] Each entry fills an eight-byte slot
// [RL4] Bytes 2-3 hold following byte count
// [RL5] Supplied format copied from request
// [RL6] Translated format copied from request
// [RL7] Reserved-area flag when any part reserved
// [RL8] Wholly reserved address may omit entries
// [RL9] Spare-sector flag only when known
// [RL10] Spare-track flag when present or unknown
// [RL11] Logical block: address first, rest zero
// [RL12] One entry per contained address
// [RL13] Bytes from index: start/end pair each
// [RL14] Log page codes: defined, reserved, vendor
// [RL15] Medium codes 00h-02h default and flexible
// [RL16] Specific flexible disk medium codes
// [RL17] Quarter-inch tape codes 40h and 44h
// [RL18] 80h-FFh vendor, rest reserved
// [RL19] Unsupported format gives illegal request
// [RL20] Flags high in byte 5, formats low
package atpb_pkg;

  // Register byte offsets
  localparam logic [9:0] ATPB_CTRL     = 10'h000;
  localparam logic [9:0] ATPB_FORMAT   = 10'h004;
  localparam logic [9:0] ATPB_FLAGS    = 10'h008;
  localparam logic [9:0] ATPB_COUNT    = 10'h00C;
  localparam logic [9:0] ATPB_SEL      = 10'h010;
  localparam logic [9:0] ATPB_SLOT_HI  = 10'h014;
  localparam logic [9:0] ATPB_SLOT_LO  = 10'h018;
  localparam logic [9:0] ATPB_STATUS   = 10'h01C;
  localparam logic [9:0] ATPB_LOG      = 10'h020;
  localparam logic [9:0] ATPB_MEDIUM   = 10'h024;
  localparam logic [9:0] ATPB_PAGE     = 10'h100;
  localparam int         ATPB_PAGE_WDS = 18;

  // Control bits
  localparam int CTRL_START = 0;
  localparam int CTRL_CLEAR = 1;
  // Flag input bits
  localparam int FL_ANY_RSV  = 0;
  localparam int FL_ALL_RSV  = 1;
  localparam int FL_SEC_KNOW = 2;
  localparam int FL_TRK_ANY  = 3;
  localparam int FL_TRK_UNK  = 4;
  localparam int FL_OMIT     = 5;
  // Field positions in the format register
  localparam int FMT_SUP_LSB = 0;
  localparam int FMT_TRN_LSB = 8;

  // Page constants
  localparam logic [7:0]  PAGE_CODE    = 8'h40;
  localparam logic [7:0]  PAGE_RSV     = 8'h00;
  localparam logic [15:0] DESC_BYTES   = 16'h0002;
  localparam int          HDR_BYTES    = 6;
  localparam int          SLOT_BYTES   = 8;
  localparam int          MAX_SLOTS    = 8;
  localparam int          RSV_AREA_BIT  = 7;
  localparam int          SPARE_SEC_BIT = 6;
  localparam int          SPARE_TRK_BIT = 5;

  // Address formats
  localparam logic [2:0] FMT_LBA = 3'h0;
  localparam logic [2:0] FMT_BFI = 3'h4;
  localparam logic [2:0] FMT_PHY = 3'h5;

  // Error report
  localparam logic [3:0] SK_NONE    = 4'h0;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NONE   = 8'h00;
  localparam logic [7:0] ASC_PARAM  = 8'h26;

  // Log page classes
  localparam logic [1:0] LOG_DEFINED  = 2'h0;
  localparam logic [1:0] LOG_RESERVED = 2'h1;
  localparam logic [1:0] LOG_VENDOR   = 2'h2;

  // Medium classes
  localparam logic [2:0] MED_DEFAULT = 3'h0;
  localparam logic [2:0] MED_FLEX_SS = 3'h1;
  localparam logic [2:0] MED_FLEX_DS = 3'h2;
  localparam logic [2:0] MED_FLEX_SP = 3'h3;
  localparam logic [2:0] MED_TAPE12  = 3'h4;
  localparam logic [2:0] MED_TAPE24  = 3'h5;
  localparam logic [2:0] MED_VENDOR  = 3'h6;
  localparam logic [2:0] MED_RSV     = 3'h7;

  // Builder states
  typedef enum logic [1:0] {
    ATPB_IDLE  = 2'b00,
    ATPB_CHECK = 2'b01,
    ATPB_READY = 2'b10,
    ATPB_ERROR = 2'b11
  } atpb_state_t;

endpackage : atpb_pkg

// ===== hdl/atpb_top.sv
`timescale 1ns/100ps
module atpb_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Block status
  output logic             page_ready,
  output logic             check_condition
);
  import atpb_pkg::*;

  // Register map, one word per offset:
  //   CTRL    write only: bit 0 start, bit 1 clear.
  //           Clear wins when both come in one word.
  //   FORMAT  bits 2:0 supplied, bits 10:8 requested.
  //   FLAGS   six facts from the address mapper:
  //           bit 0 part lies in a reserved region
  //           bit 1 all of it lies there
  //           bit 2 spare sector known to hold it
  //           bit 3 part sits on a spare track
  //           bit 4 track placement unknown
  //           bit 5 drop entries when all reserved
  //   COUNT   addresses held in the source area.
  //   SEL     slot filled by the next low half.
  //   SLOT_HI upper half, held until the low half.
  //   SLOT_LO low half; commits the slot, steps SEL.
  //   STATUS  read only: bit 0 page held,
  //           bit 1 refused, bit 2 building,
  //           bits 7:4 entry count,
  //           bits 11:8 sense key,
  //           bits 23:16 additional sense code.
  //   LOG     log page code, class in bits 9:8.
  //   MEDIUM  medium code, class in bits 10:8.
  //   PAGE    eighteen words of the built page,
  //           earliest byte in bits 31:24.
  // Other offsets read zero; writes there drop.

  // Bus timing: no wait states, so hreadyout
  // stays high and hresp low from reset on.
  // An address phase is taken on the edge where
  // hsel, htrans[1] and hready are all high.
  // Write data is used at the end of the data
  // phase. Read data is looked up at the address
  // phase and loaded on that edge, so it stands
  // through the whole data phase.
  // Limitation: a read whose address phase
  // overlaps a write data phase sees the old
  // value; an idle cycle between transfers
  // avoids this.
  // Trade-off: the early lookup costs a wide mux
  // before hrdata but keeps the slave waitless.

  // Builder: a start moves it to check, where
  // both format codes are tested. An unsupported
  // code leads to the refused state with the
  // sense fields loaded; otherwise flags and
  // entry count are fixed and the page is held.
  // The page is never stored as bytes: each read
  // of the page window builds its four bytes
  // from held fields and slots, which saves a
  // 72-byte buffer.
  // Hazard: a start while in check is ignored,
  // and a clear in that cycle loses to the build.
  // Hazard: for the logical block format the
  // slots are rewritten in place, so reload them
  // before the next build.
  // Limitation: at most eight entries; a larger
  // count is cut to eight.

  // Page layout through the page window:
  //   byte 0     page code
  //   byte 1     zero
  //   bytes 2-3  length of the rest, high first
  //   byte 4     supplied format, low bits
  //   byte 5     flags high, requested format low
  //   bytes 6 on eight bytes per entry, high
  //              byte first, entry count of them
  // Bytes past the last entry read zero.

  // Flag policy: the reserved-area flag is set
  // when any part is reserved. The spare-sector
  // flag needs a known fact, the spare-track
  // flag is also set when placement is unknown;
  // they lean opposite ways on purpose.

  // Slot loading: set SEL, then write the upper
  // half and the lower half of each address.
  // Of the two half writes only the lower one changes a slot, so
  // a half-written address is never shown. SEL
  // wraps after slot seven.

  // Reset: all state clears except hreadyout,
  // which leaves reset high so that the first
  // transfer needs no extra cycle.

  // Code classes: log and medium codes are
  // classed by pure lookups at the read, so a
  // code can be classed without a build.

  // Whole module state
  typedef struct packed {
    atpb_state_t        fsm;         // Builder state
    logic [2:0]         sup_fmt;     // Supplied format
    logic [2:0]         trn_fmt;     // Requested format
    logic [5:0]         flag_in;     // Medium facts from mapper
    logic [3:0]         count;       // Contained addresses
    logic [2:0]         sel;         // Slot being written
    logic [31:0]        hi;          // Pending upper half
    logic [7:0][63:0]   slot;        // Translated addresses
    logic [3:0]         n_ent;       // Entries in built page
    logic               reserved_area_flag; // Reserved-area flag
    logic               spare_sector_flag;  // Spare-sector flag
    logic               spare_track_flag;   // Spare-track flag
    logic [3:0]         skey;        // Sense key
    logic [7:0]         asc;         // Additional sense code
    logic [7:0]         log_code;    // Log page code to classify
    logic [7:0]         med_code;    // Medium code to classify
    logic               a_valid;     // Data phase pending
    logic               a_write;     // Pending is a write
    logic [9:0]         a_addr;      // Pending address
    logic [31:0]        hrdata;      // Read data
    logic               hreadyout;   // Always ready
    logic               hresp;       // Always okay
    logic               page_ready;  // Page built
    logic               check;       // Check condition
  } atpb_regs_t;

  atpb_regs_t r;       // Current state
  atpb_regs_t next_r;  // Next state

  // Format support test
  function automatic logic fmt_ok(input logic [2:0] f);
    fmt_ok = (f == FMT_LBA) || (f == FMT_BFI) || (f == FMT_PHY);
  endfunction : fmt_ok

  // Byte at a page position, built from held fields
  function automatic logic [7:0] page_byte(input atpb_regs_t s,
                                           input logic [6:0] idx);
    logic [15:0] len;
    logic [6:0]  off;
    logic [2:0]  e;
    logic [2:0]  b;
    logic [63:0] v;
    page_byte = PAGE_RSV;
    // [RL4] Length after header
    len = DESC_BYTES + {9'h000, s.n_ent, 3'h0};
    off = idx - 7'(HDR_BYTES);
    e   = off[5:3];
    b   = off[2:0];
    v   = s.slot[e];
    case (idx)
      // [RL1] Page code byte
      7'h00: page_byte = PAGE_CODE;
      7'h01: page_byte = PAGE_RSV;
      7'h02: page_byte = len[15:8];
      7'h03: page_byte = len[7:0];
      // [RL5] Supplied format copy
      7'h04: page_byte = {5'h00, s.sup_fmt};
      // [RL6] Translated format copy
      // [RL20] Flags high, format low
      7'h05: begin
        page_byte                = {5'h00, s.trn_fmt};
        page_byte[RSV_AREA_BIT]  = s.reserved_area_flag;
        page_byte[SPARE_SEC_BIT] = s.spare_sector_flag;
        page_byte[SPARE_TRK_BIT] = s.spare_track_flag;
      end
      default: begin
        // [RL3] Eight-byte entry slots, MSB first
        if ((idx >= 7'(HDR_BYTES)) && ({1'b0, off[6:3]} < {1'b0, s.n_ent}))
          page_byte = v[8'(63) - 8'({b, 3'h0}) -: 8];
      end
    endcase
  endfunction : page_byte

  // Log page classification
  function automatic logic [1:0] log_class(input logic [7:0] c);
    // [RL14] Defined, reserved and vendor ranges
    if (c <= 8'h07 && c != 8'h04)
      log_class = LOG_DEFINED;
    else if (c >= 8'h30 && c <= 8'h3E)
      log_class = LOG_VENDOR;
    else
      log_class = LOG_RESERVED;
  endfunction : log_class

  // Medium-type classification
  function automatic logic [2:0] med_class(input logic [7:0] c);
    med_class = MED_RSV;
    // [RL18] Upper half vendor, rest reserved
    if (c[7])
      med_class = MED_VENDOR;
    else begin
      case (c)
        // [RL15] Default and unspecified flexible
        8'h00: med_class = MED_DEFAULT;
        8'h01: med_class = MED_FLEX_SS;
        8'h02: med_class = MED_FLEX_DS;
        // [RL16] Specific flexible disks
        8'h05, 8'h06, 8'h09, 8'h0A,
        8'h0D, 8'h12, 8'h16, 8'h1A: med_class = MED_FLEX_SP;
        // [RL17] Quarter-inch tapes
        8'h40: med_class = MED_TAPE12;
        8'h44: med_class = MED_TAPE24;
        default: med_class = MED_RSV;
      endcase
    end
  endfunction : med_class

  // Next-state logic
  always_comb begin
    logic        take;
    logic [9:0]  pa;
    logic [6:0]  wbase;
    logic [4:0]  ents;
    next_r = r;
    take   = hsel && htrans[1] && hready;
    pa     = haddr[9:0];
    wbase  = 7'h00;
    ents   = 5'h00;

    // Bus answers at once, always okay
    next_r.hreadyout = 1'b1;
    next_r.hresp     = 1'b0;

    // Data phase of a pending write
    if (r.a_valid && r.a_write) begin
      case (r.a_addr)
        ATPB_CTRL: begin
          // Clear drops any built page or error
          if (hwdata[CTRL_CLEAR]) begin
            next_r.fsm  = ATPB_IDLE;
            next_r.skey = SK_NONE;
            next_r.asc  = ASC_NONE;
          end else if (hwdata[CTRL_START] && r.fsm != ATPB_CHECK) begin
            next_r.fsm = ATPB_CHECK;
          end
        end
        ATPB_FORMAT: begin
          next_r.sup_fmt = hwdata[FMT_SUP_LSB +: 3];
          next_r.trn_fmt = hwdata[FMT_TRN_LSB +: 3];
        end
        // Mapper facts, used at the next build
        ATPB_FLAGS:   next_r.flag_in  = hwdata[5:0];
        // Contained addresses
        ATPB_COUNT:   next_r.count    = hwdata[3:0];
        // Slot pointer for loading
        ATPB_SEL:     next_r.sel      = hwdata[2:0];
        // Upper half waits for its lower half
        ATPB_SLOT_HI: next_r.hi       = hwdata;
        ATPB_SLOT_LO: begin
          // Low half commits the slot and steps on
          next_r.slot[r.sel] = {r.hi, hwdata};
          next_r.sel         = r.sel + 3'h1;
        end
        // Codes held for classing
        ATPB_LOG:     next_r.log_code = hwdata[7:0];
        ATPB_MEDIUM:  next_r.med_code = hwdata[7:0];
        // Writes elsewhere are dropped
        default: ;
      endcase
    end

    // Builder sequence
    case (r.fsm)
      ATPB_IDLE: ;
      ATPB_CHECK: begin
        // [RL19] Refuse unsupported formats
        if (!fmt_ok(r.sup_fmt) || !fmt_ok(r.trn_fmt)) begin
          next_r.fsm   = ATPB_ERROR;
          next_r.skey  = SK_ILLEGAL;
          next_r.asc   = ASC_PARAM;
          next_r.n_ent = 4'h0;
        end else begin
          next_r.fsm = ATPB_READY;
          // [RL7] Any reserved part sets the flag
          next_r.reserved_area_flag = r.flag_in[FL_ANY_RSV]
                                    | r.flag_in[FL_ALL_RSV];
          // [RL9] Only a known spare sector counts
          next_r.spare_sector_flag  = r.flag_in[FL_SEC_KNOW];
          // [RL10] Unknown track placement also sets
          next_r.spare_track_flag   = r.flag_in[FL_TRK_ANY]
                                    | r.flag_in[FL_TRK_UNK];
          // [RL13] Index format takes a pair each
          if (r.trn_fmt == FMT_BFI)
            ents = {r.count, 1'b0};
          // [RL12] One entry per contained address
          else
            ents = {1'b0, r.count};
          if (ents > 5'(MAX_SLOTS))
            ents = 5'(MAX_SLOTS);
          // [RL8] Wholly reserved address may drop all
          if (r.flag_in[FL_ALL_RSV] && r.flag_in[FL_OMIT])
            ents = 5'h00;
          next_r.n_ent = ents[3:0];
          // [RL11] Block address first, rest zero
          if (r.trn_fmt == FMT_LBA) begin
            for (int i = 0; i < MAX_SLOTS; i++)
              next_r.slot[i] = {r.slot[i][31:0], 32'h0000_0000};
          end
        end
      end
      // Page held until clear or new start
      ATPB_READY: ;
      // Refusal held until clear or new start, sense data until clear
      ATPB_ERROR: ;
      // Unused code falls back to idle
      default: next_r.fsm = ATPB_IDLE;
    endcase

    // Status outputs follow the next state
    next_r.page_ready = (next_r.fsm == ATPB_READY);
    next_r.check      = (next_r.fsm == ATPB_ERROR);

    // Address phase: capture, and prepare read data now
    next_r.a_valid = take;
    next_r.a_write = take && hwrite;
    next_r.a_addr  = {pa[9:2], 2'b00};
    if (take && !hwrite) begin
      next_r.hrdata = 32'h0000_0000;
      case ({pa[9:2], 2'b00})
        ATPB_FORMAT:
          next_r.hrdata = {21'h000000, r.trn_fmt, 5'h00, r.sup_fmt};
        // Mapper facts as written
        ATPB_FLAGS:   next_r.hrdata = {26'h0000000, r.flag_in};
        // Contained addresses as written
        ATPB_COUNT:   next_r.hrdata = {28'h0000000, r.count};
        // Slot pointer, moved on by each low half
        ATPB_SEL:     next_r.hrdata = {29'h00000000, r.sel};
        // Pending upper half
        ATPB_SLOT_HI: next_r.hrdata = r.hi;
        // Builder state and sense fields
        ATPB_STATUS:
          next_r.hrdata = {8'h00, r.asc, 4'h0, r.skey,
                           r.n_ent, 1'b0, r.fsm == ATPB_CHECK,
                           r.check, r.page_ready};
        ATPB_LOG:
          next_r.hrdata = {22'h000000, log_class(r.log_code), r.log_code};
        ATPB_MEDIUM:
          next_r.hrdata = {21'h000000, med_class(r.med_code), r.med_code};
        default: begin
          // [RL2] Page window, four bytes a word, first byte high
          if (pa[9:8] == ATPB_PAGE[9:8] && pa[7:2] < 6'(ATPB_PAGE_WDS)) begin
            wbase = {pa[6:2], 2'b00};
            next_r.hrdata = {page_byte(r, wbase),
                             page_byte(r, wbase + 7'h1),
                             page_byte(r, wbase + 7'h2),
                             page_byte(r, wbase + 7'h3)};
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r           <= '0;
      r.fsm       <= ATPB_IDLE;
      r.hreadyout <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign hrdata          = r.hrdata;
  assign hreadyout       = r.hreadyout;
  assign hresp           = r.hresp;
  assign page_ready      = r.page_ready;
  assign check_condition = r.check;

endmodule : atpb_top

// ===== sim/atpb_chk.sv
`timescale 1ns/100ps
module atpb_chk
  import atpb_pkg::*;
(
  // Bus and status ports
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        page_ready,
  input wire logic        check_condition
);
  logic ctrl_dp;  // Control write now in data phase
  logic rd_take;  // Read address phase taken
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  // Track control writes so data can be tied to them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_dp <= 1'b0;
    else ctrl_dp <= hsel && htrans[1] && hready && hwrite && haddr[9:2] == 0;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_high_a: assert property (hreadyout) else $error("wait state");
  resp_okay_a: assert property (!hresp) else $error("error response");
  status_excl_a: assert property (!(page_ready && check_condition))
    else $error("ready and refused together");
  build_done_a: assert property (ctrl_dp && hwdata[0] && !hwdata[1] |->
    ##[1:4] (page_ready || check_condition)) else $error("no build");
  clear_idle_a: assert property (ctrl_dp && hwdata[1] |->
    ##2 !page_ready && !check_condition) else $error("clear lost");
  ready_fall_a: assert property ($fell(page_ready) || $fell(check_condition)
    |-> $past(ctrl_dp) || $past(ctrl_dp, 2) || $past(ctrl_dp, 3))
    else $error("status dropped alone");
  page_code_a: assert property (
    rd_take && haddr[9:2] == 8'h40 && page_ready |=> hrdata[31:16] == 16'h4000)
    else $error("page head wrong");
  sense_code_a: assert property (
    rd_take && haddr[9:2] == 8'h07 && check_condition |=> hrdata[1]
    && hrdata[11:8] == SK_ILLEGAL && hrdata[23:16] == ASC_PARAM)
    else $error("sense wrong");
  unmapped_zero_a: assert property (rd_take && haddr[9:2] inside
    {[8'h0A:8'h3F]} |=> hrdata == 32'h0) else $error("unmapped data");
endmodule : atpb_chk

// ===== sim/atpb_master.sv
`timescale 1ns/100ps
module atpb_master (
  // Bus clock and return
  input wire logic        hclk,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Request outputs
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
  end
  // One word write; waits are cut only by the bench timeout
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (!hready);
  endtask : wr
  // One word read, data taken at the end of the data phase
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0;
    do @(posedge hclk); while (!hready);
    d = hrdata;
  endtask : rd
endmodule : atpb_master

// ===== sim/atpb_tb_top.sv
`timescale 1ns/100ps
module atpb_tb_top;
  import atpb_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, page_ready, check_cond;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [63:0] slot [8];
  logic [7:0]  pg [72];
  logic [7:0]  pb;
  int fail_count, check_count, cyc, seed, n, fl, cnt, sup, trn, ok, pi, ex;
  atpb_master atpb_master_i (.hclk(hclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  atpb_top atpb_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .page_ready(page_ready), .check_condition(check_cond));
  // Report a mismatch and count every compare
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // Reference decoders kept in plain integers
  function automatic int log_cls(int c);
    if (c == 4 || (c > 7 && c < 'h30) || c == 'h3F) return 1;
    return (c >= 'h30) ? 2 : 0;
  endfunction : log_cls
  function automatic int med_cls(int c);
    case (c)
      0, 1, 2: return c;
      5, 6, 9, 'hA, 'hD, 'h12, 'h16, 'h1A: return 3;
      'h40: return 4;
      'h44: return 5;
      default: return (c >= 'h80) ? 6 : 7;
    endcase
  endfunction : med_cls
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Hang guard well above the expected run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    hresetn = 1'b0;
    seed = 34;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    atpb_master_i.rd(32'h1C, d); check("status", d, 0);
    atpb_master_i.rd(32'h80, d); check("unmapped", d, 0);
    for (int c = 0; c < 256; c++) begin
      if (c < 64) begin
        atpb_master_i.wr(32'h20, c);
        atpb_master_i.rd(32'h20, d);
        check("log", d[9:0], {log_cls(c), c[7:0]});
      end
      atpb_master_i.wr(32'h24, c);
      atpb_master_i.rd(32'h24, d);
      ex = med_cls(c) * 256 + c;
      check("medium", d[10:0], ex);
    end
    // Every format code as target except 3, which tests clear, then as source
    for (int i = 0; i < 16; i++) begin
      trn = (i < 8) ? i : 0;
      sup = (i < 8) ? 5 : i - 8;
      fl = $random(seed) & 'h3F;
      cnt = $random(seed) & 'h7;
      atpb_master_i.wr(32'h0, 32'h2);
      atpb_master_i.wr(32'h4, (trn << 8) | sup);
      atpb_master_i.wr(32'h8, fl);
      atpb_master_i.wr(32'hC, cnt);
      atpb_master_i.wr(32'h10, 0);
      foreach (slot[k]) begin
        slot[k] = {$random(seed), $random(seed)};
        atpb_master_i.wr(32'h14, slot[k][63:32]);
        atpb_master_i.wr(32'h18, slot[k][31:0]);
      end
      atpb_master_i.wr(32'h0, (i == 3) ? 32'h3 : 32'h1);
      repeat (4) @(posedge hclk);
      ok = (trn inside {0, 4, 5}) && (sup inside {0, 4, 5});
      n = (trn == 4) ? 2 * cnt : cnt;
      n = (n > 8) ? 8 : n;
      n = (fl[1] && fl[5]) ? 0 : n;
      if (i == 3) begin
        check("cleared", {page_ready, check_cond}, 0);
        continue;
      end
      check("refused", check_cond, !ok);
      atpb_master_i.rd(32'h1C, d);
      ex = ok ? (n << 4) | 1 : 32'h0026_0502;
      check("status", d & 32'h00FF_0FF3, ex);
      if (!ok) continue;
      foreach (pg[k]) pg[k] = 0;
      pg[0] = 8'h40;
      {pg[2], pg[3]} = 2 + 8 * n;
      pg[4] = sup;
      pg[5] = {fl[0] | fl[1], fl[2], fl[3] | fl[4], 2'b0, trn[2:0]};
      for (int e = 0; e < n; e++)
        for (int b = 0; b < 8; b++)
          pg[6 + 8 * e + b] = (trn == 0) ? ((b < 4) ?
            slot[e][31 - 8 * b -: 8] : 8'h0) : slot[e][63 - 8 * b -: 8];
      for (int w = 0; w < 18; w++) begin
        atpb_master_i.rd(32'h100 + 4 * w, d);
        for (int b = 0; b < 4; b++) begin
          pi = 4 * w + b;
          pb = d[31 - 8 * b -: 8];
          if (pi < 4)
            check("head", pb, pg[pi]);
          else if (pi == 4)
            check("supplied", pb, pg[pi]);
          else if (pi == 5) begin
            check("flags", pb[7:5], pg[pi][7:5]);
            check("format", pb[4:0], pg[pi][4:0]);
          end else if (pi < 6 + 8 * n)
            check("entry", pb, pg[pi]);
        end
      end
    end
    close_out();
  end
endmodule : atpb_tb_top
bind atpb_top atpb_chk atpb_chk_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .page_ready(page_ready),
  .check_condition(check_condition));
